// file: logic/etc_pkg.sv
/*
 * package for the 8/16-bit timer/counter: register offsets, field positions,
 * reset values and timing counts.
 * assumes a 32-bit classic wishbone slave, one aligned word per register.
 */
package etc_pkg;
    // ****************************************
    // register map
    // ****************************************
    localparam logic [3:0] ETC_OFS_CONTROL = 4'h0;
    localparam logic [3:0] ETC_OFS_COUNT_LOW = 4'h4;
    localparam logic [3:0] ETC_OFS_HIGH_BUF = 4'h8;
    localparam logic [3:0] ETC_OFS_STATUS = 4'hC;
    // ****************************************
    // control and status fields
    // ****************************************
    localparam int ETC_BIT_RUN = 7;
    localparam int ETC_BIT_WIDTH = 6;
    localparam int ETC_BIT_SOURCE = 5;
    localparam int ETC_BIT_EDGE = 4;
    localparam int ETC_BIT_BYPASS = 3;
    localparam int ETC_RATIO_MSB = 2;
    localparam logic [7:0] ETC_CONTROL_RST = 8'hFF;
    localparam int ETC_BIT_OVF = 0;
    // ****************************************
    // timing
    // ****************************************
    localparam int ETC_CYC_PER_INSTR = 4;
    localparam int ETC_WRITE_HOLD_INSTR = 2;
    localparam int ETC_WRITE_HOLD_CYC = ETC_CYC_PER_INSTR * ETC_WRITE_HOLD_INSTR;
    localparam int ETC_PRESCALE_W = 8;
endpackage

// file: logic/etc_edge_sync.sv
/*
 * synchroniser and selectable edge detector for the external count pin.
 * assumes the pin is held at least two clocks in each level.
 */
`timescale 1ns/100ps
module etc_edge_sync (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic pin_i,
    input wire logic falling_i,
    output logic edge_o
);
    logic meta_r;
    logic sync_r;
    logic last_r;

    // three flops; edge_o compares sync_r with last_r
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            last_r <= 1'b0;
        end else begin
            meta_r <= pin_i;
            sync_r <= meta_r;
            last_r <= sync_r;
        end
    end

    assign edge_o = falling_i ? (last_r & ~sync_r) : (~last_r & sync_r); // RULE_07 RULE_15
endmodule

// file: logic/etc_timer.sv
/*
 * 8/16-bit timer/counter with 8-bit prescaler behind a classic wishbone slave.
 * assumes synchronous inputs except the count pin, which is synchronised here.
 */
// Local design decisions: the Wishbone register port and the register offsets.
// Overview of operation
// RULE_01 - counter runs as 8-bit or 16-bit
// RULE_02 - overflow on wrap from all ones
// RULE_03 - own 8-bit prescaler, software-selected ratio
// RULE_04 - bit 7 runs or halts counting
// RULE_05 - bit 6 set means 8-bit width
// RULE_06 - bit 5 set counts external pin edges
// RULE_07 - bit 4 set selects falling edge
// RULE_08 - bit 3 set bypasses the prescaler
// RULE_09 - ratio code 000 divides by 2, 111 by 256
// RULE_10 - control fully read/write, resets to FFh
// RULE_11 - low byte write holds counting two instructions
// RULE_12 - low read latches high; low write loads high (code latches on a low read only in 16-bit width)
// RULE_13 - low byte write clears prescaler count (code clears it only while the prescaler is not bypassed)
// RULE_14 - overflow sets flag software reads and clears
// RULE_15 - external pin synchronised and edge-detected
`timescale 1ns/100ps
module etc_timer (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [3:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic count_pin_i,
    output logic overflow_flag_o
);
    import etc_pkg::*;

    typedef enum logic [1:0] {
        ETC_IDLE = 2'b01,
        ETC_ACK = 2'b10
    } etc_bus_e;

    // ****************************************
    // bus slave
    // ****************************************
    etc_bus_e bus_r;
    logic req;
    logic wr_req;
    logic rd_req;
    logic wr_low;
    logic rd_low;
    logic wr_ctrl;
    logic wr_hbuf;
    logic wr_stat;

    // one wait state, then a single-cycle ack
    assign req = cyc_i & stb_i & (bus_r == ETC_IDLE);
    // writes with the low byte lane off are dropped, still acked
    assign wr_req = req & we_i & sel_i[0];
    assign rd_req = req & ~we_i;
    assign wr_low = wr_req & (adr_i == ETC_OFS_COUNT_LOW);
    assign rd_low = rd_req & (adr_i == ETC_OFS_COUNT_LOW);
    assign wr_ctrl = wr_req & (adr_i == ETC_OFS_CONTROL);
    assign wr_hbuf = wr_req & (adr_i == ETC_OFS_HIGH_BUF);
    assign wr_stat = wr_req & (adr_i == ETC_OFS_STATUS);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bus_r <= ETC_IDLE;
        end else begin
            case (bus_r)
                ETC_IDLE: begin
                    if (cyc_i & stb_i) begin
                        bus_r <= ETC_ACK;
                    end
                end
                ETC_ACK: begin
                    // never stretched; the master drops the request now
                    bus_r <= ETC_IDLE;
                end
                default: begin
                    bus_r <= ETC_IDLE;
                end
            endcase
        end
    end

    // ack is a flop of its own so the port stays glitch free
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
        end else begin
            ack_o <= req;
        end
    end

    // ****************************************
    // control register
    // ****************************************
    logic [7:0] control_r;
    logic run_enable;
    logic width_select;
    logic source_select;
    logic edge_select;
    logic prescaler_bypass;
    logic [2:0] prescale_ratio;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            control_r <= ETC_CONTROL_RST; // RULE_10
        end else if (wr_ctrl) begin
            control_r <= dat_i[7:0]; // RULE_10
        end
    end

    assign run_enable = control_r[ETC_BIT_RUN];
    assign width_select = control_r[ETC_BIT_WIDTH];
    assign source_select = control_r[ETC_BIT_SOURCE];
    assign edge_select = control_r[ETC_BIT_EDGE];
    assign prescaler_bypass = control_r[ETC_BIT_BYPASS];
    assign prescale_ratio = control_r[ETC_RATIO_MSB:0];

    // ****************************************
    // clock source
    // ****************************************
    logic [1:0] instr_div_r;
    logic instr_tick;
    logic pin_edge;
    logic src_tick;

    // instruction cycle is four core clocks
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            instr_div_r <= 2'h0;
        end else begin
            instr_div_r <= instr_div_r + 2'h1;
        end
    end
    assign instr_tick = (instr_div_r == 2'(ETC_CYC_PER_INSTR - 1));

    etc_edge_sync u_edge (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i(count_pin_i),
        .falling_i(edge_select),
        .edge_o(pin_edge)
    );

    assign src_tick = source_select ? pin_edge : instr_tick; // RULE_06

    // ****************************************
    // prescaler
    // ****************************************
    logic [ETC_PRESCALE_W-1:0] pre_r;
    logic [ETC_PRESCALE_W-1:0] pre_mask;
    logic pre_tick;
    logic cnt_tick;

    logic pre_clr;
    logic pre_run;

    // low-bit masks: 000 -> /2 up to 111 -> /256
    always_comb begin
        pre_mask = 8'h01;
        case (prescale_ratio)
            3'h0: pre_mask = 8'h01; // RULE_09
            3'h1: pre_mask = 8'h03;
            3'h2: pre_mask = 8'h07;
            3'h3: pre_mask = 8'h0F;
            3'h4: pre_mask = 8'h1F;
            3'h5: pre_mask = 8'h3F;
            3'h6: pre_mask = 8'h7F;
            3'h7: pre_mask = 8'hFF; // RULE_09
            default: pre_mask = 8'h01;
        endcase
    end
    assign pre_tick = src_tick & ((pre_r & pre_mask) == pre_mask);

    // a write clears the count only while assigned; bypass keeps it
    assign pre_clr = wr_low & ~prescaler_bypass; // RULE_13
    assign pre_run = src_tick & run_enable & ~prescaler_bypass; // RULE_03

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pre_r <= '0;
        end else if (pre_clr) begin
            pre_r <= '0; // RULE_13
        end else if (pre_run) begin
            pre_r <= pre_r + ETC_PRESCALE_W'(1); // RULE_03
        end
    end

    assign cnt_tick = prescaler_bypass ? src_tick : pre_tick; // RULE_08

    // ****************************************
    // counter
    // ****************************************
    logic [7:0] low_r;
    logic [7:0] high_r;
    logic [7:0] high_buf_r;
    logic [3:0] hold_r;
    logic hold_done;
    logic cnt_adv;
    logic wrap;

    // an overflow only when the active width is all ones
    assign wrap = (low_r == 8'hFF) & (width_select | (high_r == 8'hFF)); // RULE_02 RULE_05
    assign hold_done = (hold_r == 4'h0); // RULE_11
    // a low-byte write owns the counter in its own cycle
    assign cnt_adv = cnt_tick & run_enable & hold_done & ~wr_low; // RULE_04 RULE_11

    // ****************************************
    // write hold window
    // ****************************************
    // counted in core clocks, two instruction cycles long after the write cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hold_r <= 4'h0;
        end else if (wr_low) begin
            hold_r <= 4'(ETC_WRITE_HOLD_CYC); // RULE_11
        end else if (!hold_done) begin
            hold_r <= hold_r - 4'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            low_r <= 8'h00;
        end else if (wr_low) begin
            low_r <= dat_i[7:0];
        end else if (cnt_adv) begin
            low_r <= low_r + 8'h01;
        end
    end

    // high byte does not count in 8-bit width; a low write still loads it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            high_r <= 8'h00;
        end else if (wr_low) begin
            high_r <= high_buf_r; // RULE_12
        end else if (cnt_adv & ~width_select & (low_r == 8'hFF)) begin
            high_r <= high_r + 8'h01; // RULE_01
        end
    end

    // ****************************************
    // high buffer
    // ****************************************
    // latched on a low read in 16-bit width so software sees a coherent 16-bit pair
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            high_buf_r <= 8'h00;
        end else if (rd_low & ~width_select) begin
            high_buf_r <= high_r; // RULE_12
        end else if (wr_hbuf) begin
            high_buf_r <= dat_i[7:0];
        end
    end

    // ****************************************
    // overflow flag
    // ****************************************
    logic flag_set;
    logic flag_clr;

    assign flag_set = cnt_adv & wrap; // RULE_14
    assign flag_clr = wr_stat & dat_i[ETC_BIT_OVF]; // RULE_14

    // set wins over a same-cycle software clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            overflow_flag_o <= 1'b0;
        end else if (flag_set) begin
            overflow_flag_o <= 1'b1; // RULE_14
        end else if (flag_clr) begin
            overflow_flag_o <= 1'b0; // RULE_14
        end
    end

    // ****************************************
    // read data
    // ****************************************
    logic [31:0] rd_word;

    // unmapped offsets read as zero
    always_comb begin
        rd_word = 32'h0000_0000;
        case (adr_i)
            ETC_OFS_CONTROL: rd_word = {24'h00_0000, control_r}; // RULE_10
            ETC_OFS_COUNT_LOW: rd_word = {24'h00_0000, low_r};
            ETC_OFS_HIGH_BUF: rd_word = {24'h00_0000, high_buf_r}; // RULE_12
            ETC_OFS_STATUS: rd_word = {31'h0000_0000, overflow_flag_o}; // RULE_14
            default: rd_word = 32'h0000_0000;
        endcase
    end

    // held until the next read so a slow master may take it late
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h0000_0000;
        end else if (rd_req) begin
            dat_o <= rd_word;
        end
    end
endmodule

// file: test/etc_pin_model.sv
/* external count signal source for the timer bench.
   assumes the bench clock; each level is held four clocks. */
`timescale 1ns/100ps
module etc_pin_model (
    input wire logic clk_i,
    output logic pin_o
);
    // ********
    // edge maker
    // ********
    initial pin_o = 1'b0;
    // slow enough for the two-flop synchroniser
    task automatic toggle(input int n);
        for (int i = 0; i < n; i++) begin
            repeat (4) @(posedge clk_i);
            pin_o <= ~pin_o;
        end
    endtask
endmodule

// file: test/etc_timer_sva.sv
/* checker for the timer bus and flag ports.
   assumes a classic wishbone master and the package map. */
`timescale 1ns/100ps
module etc_timer_sva (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [3:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    input wire logic count_pin_i,
    input wire logic overflow_flag_o
);
    import etc_pkg::*;
    // ********
    // control shadow and properties
    // ********
    logic [7:0] ctl_r;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_take;
        cyc_i && stb_i && !ack_o;
    endsequence
    sequence s_clr;
        s_take ##0 we_i && sel_i[0] && dat_i[0] && adr_i == ETC_OFS_STATUS;
    endsequence
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctl_r <= ETC_CONTROL_RST;
        end else if (cyc_i && stb_i && !ack_o && we_i && sel_i[0] && adr_i == ETC_OFS_CONTROL) begin
            ctl_r <= dat_i[7:0];
        end
    end
    a_ack_answer: assert property (s_take |=> ack_o) else $error("no ack");
    a_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack too long");
    a_ctrl_readback: assert property (s_take ##0 !we_i && adr_i == ETC_OFS_CONTROL |=>
        dat_o[7:0] == ctl_r) else $error("control readback");
    a_unmapped_zero: assert property (s_take ##0 !we_i && adr_i[1:0] != 2'h0 |=>
        dat_o == 32'h0) else $error("unmapped read");
    a_dat_hold: assert property ($changed(dat_o) |-> ack_o && $past(!we_i)) else $error("read data moved");
    a_flag_clear: assert property (s_clr |=> !overflow_flag_o) else $error("flag not cleared");
    a_flag_sticky: assert property ($fell(overflow_flag_o) |-> $past(cyc_i && stb_i && we_i &&
        adr_i == ETC_OFS_STATUS && dat_i[0])) else $error("flag dropped");
    a_flag_needs_run: assert property ($rose(overflow_flag_o) |-> ctl_r[7] || $past(ctl_r[7]) ||
        $past(ctl_r[7], 2) || $past(ctl_r[7], 3)) else $error("overflow while halted");
endmodule
bind etc_timer etc_timer_sva etc_timer_sva_i (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
    .dat_o, .ack_o, .count_pin_i, .overflow_flag_o);

// file: test/etc_timer_test.sv
/* self-checking bench for the timer.
   assumes the pin model and checker are compiled first. */
`timescale 1ns/100ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_fail++; $display("ERROR %0t mismatch", $time); end end
module etc_timer_test;
    import etc_pkg::*;
    // ********
    // rows: sel, write, expected
    // ********
    logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, ack_o, count_pin_i, overflow_flag_o;
    logic [3:0] adr_i = 0, sel_i = 0;
    logic [31:0] dat_i = 0, dat_o, rd;
    logic [19:0] rows [4] = '{20'hFA5A5, 20'hE00A5, 20'hF5A5A, 20'h10000};
    int n_fail = 0, checks = 0;
    etc_timer etc_timer_i (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
        .count_pin_i, .overflow_flag_o);
    etc_pin_model etc_pin_model_i (.clk_i, .pin_o(count_pin_i));
    initial forever #4 clk_i = ~clk_i;
    task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d, input logic [3:0] s = 4'hF);
        int t;
        t = 0;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        sel_i <= s;
        dat_i <= {24'h0, d};
        @(posedge clk_i);
        while (ack_o !== 1'b1 && t < 20) begin
            @(posedge clk_i);
            t++;
        end
        if (t == 20) n_fail++;
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic wait_flag();
        for (int i = 0; i < 60 && overflow_flag_o !== 1'b1; i++) @(posedge clk_i);
    endtask
    task automatic test_done();
        $display("TB: checks %0d fails %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk_i);
        n_fail++;
        test_done();
    end
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        bus(0, ETC_OFS_CONTROL, 0);
        `CHK(rd[7:0], ETC_CONTROL_RST)
        foreach (rows[i]) begin
            bus(1, ETC_OFS_CONTROL, rows[i][15:8], rows[i][19:16]);
            bus(0, ETC_OFS_CONTROL, 0);
            `CHK(rd[7:0], rows[i][7:0])
        end
        bus(0, 4'h2, 0);
        `CHK(rd, 32'h0)
        $display("TB: register test done");
        bus(1, ETC_OFS_HIGH_BUF, 8'h34);
        bus(1, ETC_OFS_COUNT_LOW, 8'h56);
        bus(1, ETC_OFS_HIGH_BUF, 8'h00);
        repeat (20) @(posedge clk_i);
        bus(0, ETC_OFS_COUNT_LOW, 0);
        `CHK(rd[7:0], 8'h56)
        bus(0, ETC_OFS_HIGH_BUF, 0);
        `CHK(rd[7:0], 8'h34)
        bus(1, ETC_OFS_HIGH_BUF, 8'hFF);
        bus(1, ETC_OFS_COUNT_LOW, 8'hFE);
        bus(1, ETC_OFS_CONTROL, 8'h88);
        wait_flag();
        `CHK(overflow_flag_o, 1'b1)
        bus(0, ETC_OFS_COUNT_LOW, 0);
        bus(0, ETC_OFS_HIGH_BUF, 0);
        `CHK(rd[7:0], 8'h00)
        bus(1, ETC_OFS_STATUS, 8'h01);
        `CHK(overflow_flag_o, 1'b0)
        $display("TB: wide test done");
        bus(1, ETC_OFS_CONTROL, 8'hC8);
        bus(1, ETC_OFS_COUNT_LOW, 8'hFD);
        bus(0, ETC_OFS_COUNT_LOW, 0);
        `CHK(rd[7:0], 8'hFD)
        wait_flag();
        `CHK(overflow_flag_o, 1'b1)
        bus(1, ETC_OFS_STATUS, 8'h01);
        for (int r = 0; r < 3; r++) begin
            bus(1, ETC_OFS_CONTROL, 8'hC0 | r[7:0]);
            bus(1, ETC_OFS_COUNT_LOW, 8'h00);
            repeat (80 << r) @(posedge clk_i);
            bus(0, ETC_OFS_COUNT_LOW, 0);
            `CHK(rd[7:0] inside {[8'h08:8'h0B]}, 1'b1)
        end
        // bypass: one count per instruction tick once the hold ends
        bus(1, ETC_OFS_CONTROL, 8'hC8);
        bus(1, ETC_OFS_COUNT_LOW, 8'h00);
        repeat (40) @(posedge clk_i);
        bus(0, ETC_OFS_COUNT_LOW, 0);
        `CHK(rd[7:0] inside {[8'h08:8'h09]}, 1'b1)
        // each low write restarts a /256 prescaler long before it ends
        bus(1, ETC_OFS_CONTROL, 8'hC7);
        for (int k = 0; k < 3; k++) begin
            bus(1, ETC_OFS_COUNT_LOW, 8'h00);
            repeat (700) @(posedge clk_i);
            bus(0, ETC_OFS_COUNT_LOW, 0);
            `CHK(rd[7:0], 8'h00)
        end
        $display("TB: prescale test done");
        // pin edges wait out the write hold window
        bus(1, ETC_OFS_CONTROL, 8'hE8);
        bus(1, ETC_OFS_COUNT_LOW, 8'h00);
        repeat (10) @(posedge clk_i);
        etc_pin_model_i.toggle(5);
        repeat (10) @(posedge clk_i);
        bus(0, ETC_OFS_COUNT_LOW, 0);
        `CHK(rd[7:0], 8'h03)
        etc_pin_model_i.toggle(1);
        bus(1, ETC_OFS_CONTROL, 8'hF8);
        bus(1, ETC_OFS_COUNT_LOW, 8'h00);
        repeat (10) @(posedge clk_i);
        etc_pin_model_i.toggle(5);
        repeat (10) @(posedge clk_i);
        bus(0, ETC_OFS_COUNT_LOW, 0);
        `CHK(rd[7:0], 8'h02)
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        bus(0, ETC_OFS_CONTROL, 0);
        `CHK(rd[7:0], ETC_CONTROL_RST)
        $display("TB: pin and reset test done");
        test_done();
    end
endmodule
